// File: src/rcs_pkg.sv
// rcs_pkg: constants, types and pin carriers for the rectifier control block
// Function
// - output on only while on-request pin low; off once it or seat pin released
// - seat-detect pin qualifies enable: off before unmating, on only after mating
// - margin input open or above upper threshold selects factory default setpoint
// - bus-commanded setpoint overrides pin setpoint until controller power cycles
// - after controller restart, setpoint follows the margin pin again
// - insertion-sense level above threshold enables eeprom write protection
// - momentary low on selector reset pin returns selector to default
// - slot level decodes to two address bits, largest resistor 00, smallest 11
// - shelf level classified in eight; odd levels give bit2 1, even give 0
// - capacity indicator high at high-line rating, low at low-line rating
// - power-fail warning high while output delivered, low ahead of decay
// - replacement fault pin low on fan, temperature, overvoltage or internal fault
// - status and alarm bits follow the present condition, never frozen
// - communication error bits stay set until clear-faults
// - changed bit set whenever status content changes since last read
// - with auto restart on, restart after protective shutdown and raise alert
// - automatic restart sets a restart bit for the host
// - status read clears the restart and changed bits, not the live or communication error bits
// - two management channels independent; either host may take over anytime
// - selector connects channel 0 after start-up
// - alert latched low on change until cleared; reasserts if condition persists
package rcs_pkg;
    localparam int          CLK_MHZ   = 125;
    localparam int          FILT_NS   = 2000;
    localparam logic [7:0]  FILT_CYC  = 8'((FILT_NS * CLK_MHZ + 999) / 1000);
    localparam int          ADC_FS_MV = 3600;

    function automatic logic [7:0] rcs_mv2c(input int mv);
        return 8'((mv * 255) / ADC_FS_MV);
    endfunction

    localparam logic [7:0]  MARGIN_HI  = rcs_mv2c(3000);
    localparam logic [7:0]  WP_LEVEL   = rcs_mv2c(1000);
    localparam logic [7:0]  SLOT_B0    = rcs_mv2c(2201);
    localparam logic [7:0]  SLOT_B1    = rcs_mv2c(1584);
    localparam logic [7:0]  SLOT_B2    = rcs_mv2c(948);
    localparam logic [7:0]  SHELF_MIN [7] = '{rcs_mv2c(3000), rcs_mv2c(2600), rcs_mv2c(2180),
                                             rcs_mv2c(1730), rcs_mv2c(1290), rcs_mv2c(840),
                                             rcs_mv2c(300)};
    localparam logic [7:0]  SETPT_DEFAULT = 8'h36;

    localparam logic [7:0]  REG_CTRL   = 8'h00;
    localparam logic [7:0]  REG_SETPT  = 8'h04;
    localparam logic [7:0]  REG_STATUS = 8'h08;
    localparam logic [7:0]  REG_ADDR   = 8'h0C;
    localparam logic [7:0]  REG_PINS   = 8'h10;
    localparam int          CTRL_AUTO  = 0;
    localparam int          CTRL_CLRF  = 1;
    localparam int          CTRL_CHAN  = 2;
    localparam int          ST_PEC     = 8;
    localparam int          ST_DATA    = 9;
    localparam int          ST_RESTART = 12;
    localparam int          ST_CHANGED = 13;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;

    typedef struct packed {
        logic remote_on_n;
        logic seat_n;
        logic sel_reset_n;
        logic fan_fail;
        logic ot_warn;
        logic ot_shut;
        logic ov_shut;
        logic int_fault;
        logic vin_fault;
        logic high_line;
        logic decay_warn;
    } rcs_pins_t;

    typedef struct packed {
        logic [7:0] margin;
        logic [7:0] present;
        logic [7:0] slot;
        logic [7:0] shelf;
    } rcs_adc_t;

    localparam rcs_pins_t PINS_RST = 11'h700;

    typedef enum logic [1:0] {ST_OFF, ST_ON, ST_PROT, ST_LATCH} rcs_state_t;
endpackage

// File: src/rcs_top.sv
// rcs_top: rectifier control, status, address decode and ahb-lite register slave
`timescale 1ns/100ps
module rcs_top (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               ce,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire rcs_pkg::rcs_pins_t pins,
    input  wire rcs_pkg::rcs_adc_t  adc,
    input  wire logic               pec_err_pulse,
    input  wire logic               data_err_pulse,
    output logic                    main_out_en,
    output logic                    capacity_hi,
    output logic                    power_ok_warn,
    output logic                    fault_n,
    output logic                    alert_n,
    output logic                    eeprom_wp,
    output logic                    sel_channel,
    output logic                    bus_addr_bit2,
    output logic                    bus_addr_bit1,
    output logic                    bus_addr_bit0,
    output logic      [7:0]         setpoint,
    output logic                    setpoint_from_bus
);
    import rcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // synchronise and filter all pin inputs
    localparam int NB = $bits(rcs_pins_t) + $bits(rcs_adc_t);
    localparam logic [NB-1:0] FILT_RST = {PINS_RST, 32'h0000_0000};

    logic [NB-1:0] raw;
    logic [NB-1:0] sync1_reg;
    logic [NB-1:0] sync2_reg;
    logic [NB-1:0] filt;
    rcs_pins_t     pf;
    rcs_adc_t      af;

    assign raw = {pins, adc};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= FILT_RST;
            sync2_reg <= FILT_RST;
        end else if (ce) begin
            sync1_reg <= raw;
            sync2_reg <= sync1_reg;
        end
    end

    // per-bit filter: an adc word may settle bit by bit, acceptable for slow levels
    generate
        for (genvar g = 0; g < NB; g++) begin : g_filt
            logic [7:0] cnt_reg;
            logic       f_reg;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cnt_reg <= 8'h00;
                    f_reg   <= FILT_RST[g];
                end else if (ce) begin
                    if (sync2_reg[g] == f_reg) begin
                        cnt_reg <= 8'h00;
                    end else if (cnt_reg == FILT_CYC - 8'h01) begin
                        cnt_reg <= 8'h00;
                        f_reg   <= sync2_reg[g];
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
            end
            assign filt[g] = f_reg;
        end
    endgenerate

    assign {pf, af} = filt;

    ////////////////////////////////////////////////////////////////////////////
    // level decoding
    function automatic logic [2:0] shelf_level(input logic [7:0] v);
        logic [2:0] lvl;
        lvl = 3'h7;
        for (int i = 6; i >= 0; i--) begin
            if (v >= SHELF_MIN[i]) begin
                lvl = 3'(i);
            end
        end
        return lvl;
    endfunction

    logic [2:0] shelf_idx;
    logic [1:0] slot_bits;
    logic       margin_hi;
    logic       wp_w;

    assign shelf_idx = shelf_level(af.shelf);
    assign slot_bits = (af.slot >= SLOT_B0) ? 2'h0 :
                       (af.slot >= SLOT_B1) ? 2'h1 :
                       (af.slot >= SLOT_B2) ? 2'h2 : 2'h3;
    assign margin_hi = af.margin > MARGIN_HI;
    assign wp_w      = af.present > WP_LEVEL;

    ////////////////////////////////////////////////////////////////////////////
    // output state machine
    rcs_state_t state_reg;
    rcs_state_t state_next;
    logic       req_w;
    logic       prot_w;
    logic       auto_reg;
    logic       restart_evt;
    logic       recycle_evt;

    assign req_w  = !pf.remote_on_n && !pf.seat_n;
    assign prot_w = pf.ot_shut || pf.ov_shut;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (req_w && !prot_w) state_next = ST_ON;
            end
            ST_ON: begin
                if (!req_w) state_next = ST_OFF;
                else if (prot_w) state_next = auto_reg ? ST_PROT : ST_LATCH;
            end
            ST_PROT: begin
                if (!req_w) state_next = ST_OFF;
                else if (!prot_w) state_next = ST_ON;
            end
            ST_LATCH: begin
                if (!req_w) state_next = ST_OFF;
            end
            default: state_next = ST_OFF;
        endcase
    end

    assign restart_evt = (state_reg == ST_PROT) && (state_next == ST_ON);
    assign recycle_evt = (state_reg == ST_OFF) && (state_next == ST_ON);

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave
    logic        wr_pend_reg;
    logic [7:0]  waddr_reg;
    logic [31:0] hrdata_reg;
    logic        hreadyout_reg;
    logic        hresp_reg;
    logic        ap_w;
    logic        dp_wr;
    logic        status_rd;
    logic        clrf_w;
    logic [31:0] rd_data;

    assign ap_w      = hsel && (htrans == HTRANS_NONSEQ) && hready;
    assign dp_wr     = wr_pend_reg && hready;
    assign status_rd = ap_w && !hwrite && (haddr[7:0] == REG_STATUS);
    assign clrf_w    = dp_wr && (waddr_reg == REG_CTRL) && hwdata[CTRL_CLRF];

    ////////////////////////////////////////////////////////////////////////////
    // status and alert
    logic [6:0]  present_w;
    logic [6:0]  prev_reg;
    logic        chg_evt;
    logic        pec_reg;
    logic        data_reg;
    logic        restart_reg;
    logic        changed_reg;
    logic        alert_n_reg;
    logic        alarm_evt;
    logic        alarm_clr;
    logic        alarm_cond;
    logic [31:0] status_w;

    assign present_w  = {!main_out_en, pf.vin_fault, pf.int_fault, pf.ov_shut,
                         pf.ot_shut, pf.ot_warn, pf.fan_fail};
    assign chg_evt    = present_w != prev_reg;
    assign alarm_evt  = chg_evt || pec_err_pulse || data_err_pulse || restart_evt;
    assign alarm_clr  = status_rd || clrf_w || recycle_evt;
    assign alarm_cond = (|present_w[5:0]) || pec_reg || data_reg;
    assign status_w   = {18'h0, changed_reg, restart_reg, 2'h0, data_reg, pec_reg, 1'b0, present_w};

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic       chan_reg;
    logic       sw_ovr_reg;
    logic [7:0] sw_setpt_reg;
    logic [7:0] setpt_reg;
    logic       out_en_reg;
    logic       cap_reg;
    logic       pok_reg;
    logic       fault_n_reg;
    logic       wp_reg;
    logic [2:0] addr_reg;
    logic [7:0] setpt_next;

    // pin setpoint is the filtered margin code itself
    assign setpt_next = sw_ovr_reg ? sw_setpt_reg :
                        margin_hi  ? SETPT_DEFAULT : af.margin;

    assign rd_data = (haddr[7:0] == REG_CTRL)   ? {29'h0, chan_reg, 1'b0, auto_reg} :
                     (haddr[7:0] == REG_SETPT)  ? {8'h0, setpt_reg, 7'h0, sw_ovr_reg, sw_setpt_reg} :
                     (haddr[7:0] == REG_STATUS) ? status_w :
                     (haddr[7:0] == REG_ADDR)   ? {24'h0, margin_hi, shelf_idx, wp_reg, addr_reg} :
                     (haddr[7:0] == REG_PINS)   ? {21'h0, pf} : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            waddr_reg   <= 8'h00;
            hrdata_reg  <= 32'h0000_0000;
            hreadyout_reg <= 1'b1;
            hresp_reg   <= 1'b0;
        end else if (ce) begin
            // zero wait states and never an error, so the answer is always ready and okay
            hreadyout_reg <= 1'b1;
            hresp_reg   <= 1'b0;
            wr_pend_reg <= ap_w && hwrite && (hsize == HSIZE_WORD);
            if (ap_w) waddr_reg <= haddr[7:0];
            if (ap_w && !hwrite) hrdata_reg <= rd_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            auto_reg     <= 1'b0;
            chan_reg     <= 1'b0;
            sw_ovr_reg   <= 1'b0;
            sw_setpt_reg <= 8'h00;
        end else if (ce) begin
            if (dp_wr && waddr_reg == REG_CTRL) auto_reg <= hwdata[CTRL_AUTO];
            if (!pf.sel_reset_n) chan_reg <= 1'b0;
            else if (dp_wr && waddr_reg == REG_CTRL) chan_reg <= hwdata[CTRL_CHAN];
            if (dp_wr && waddr_reg == REG_SETPT) begin
                sw_ovr_reg   <= 1'b1;
                sw_setpt_reg <= hwdata[7:0];
            end
        end
    end

    // set wins over clear on every sticky bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_reg    <= 7'h40;
            pec_reg     <= 1'b0;
            data_reg    <= 1'b0;
            restart_reg <= 1'b0;
            changed_reg <= 1'b0;
            alert_n_reg <= 1'b1;
        end else if (ce) begin
            prev_reg    <= present_w;
            pec_reg     <= pec_err_pulse || (pec_reg && !clrf_w);
            data_reg    <= data_err_pulse || (data_reg && !clrf_w);
            restart_reg <= restart_evt || (restart_reg && !status_rd);
            // comm errors and restarts change the status word too, not only live bits
            changed_reg <= alarm_evt || (changed_reg && !status_rd);
            alert_n_reg <= !(alarm_evt || (alarm_clr ? alarm_cond : !alert_n_reg));
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg   <= ST_OFF;
            out_en_reg  <= 1'b0;
            cap_reg     <= 1'b0;
            pok_reg     <= 1'b0;
            fault_n_reg <= 1'b1;
            wp_reg      <= 1'b0;
            addr_reg    <= 3'h0;
            setpt_reg   <= SETPT_DEFAULT;
        end else if (ce) begin
            state_reg   <= state_next;
            out_en_reg  <= state_next == ST_ON;
            cap_reg     <= pf.high_line;
            pok_reg     <= (state_next == ST_ON) && !pf.decay_warn;
            fault_n_reg <= !(pf.fan_fail || pf.ot_warn || pf.ot_shut || pf.ov_shut || pf.int_fault);
            wp_reg      <= wp_w;
            addr_reg    <= {shelf_idx[0], slot_bits};
            setpt_reg   <= setpt_next;
        end
    end

    assign hrdata            = hrdata_reg;
    assign hreadyout         = hreadyout_reg;
    assign hresp             = hresp_reg;
    assign main_out_en       = out_en_reg;
    assign capacity_hi       = cap_reg;
    assign power_ok_warn     = pok_reg;
    assign fault_n           = fault_n_reg;
    assign alert_n           = alert_n_reg;
    assign eeprom_wp         = wp_reg;
    assign sel_channel       = chan_reg;
    assign bus_addr_bit2     = addr_reg[2];
    assign bus_addr_bit1     = addr_reg[1];
    assign bus_addr_bit0     = addr_reg[0];
    assign setpoint          = setpt_reg;
    assign setpoint_from_bus = sw_ovr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_req_off;
        @(posedge hclk) disable iff (!hresetn) (ce && pf.remote_on_n) |=> !out_en_reg;
    endproperty
    a_req_off: assert property (p_req_off) else $error("output on without request");

    property p_seat_off;
        @(posedge hclk) disable iff (!hresetn) (ce && pf.seat_n) |=> !out_en_reg;
    endproperty
    a_seat_off: assert property (p_seat_off) else $error("output on while unseated");

    property p_default_setpt;
        @(posedge hclk) disable iff (!hresetn)
            (ce && !sw_ovr_reg && margin_hi) |=> (setpt_reg == SETPT_DEFAULT);
    endproperty
    a_default_setpt: assert property (p_default_setpt) else $error("default setpoint missed");

    property p_bus_setpt;
        @(posedge hclk) disable iff (!hresetn)
            (ce && sw_ovr_reg) |=> (sw_ovr_reg && setpt_reg == $past(sw_setpt_reg));
    endproperty
    a_bus_setpt: assert property (p_bus_setpt) else $error("bus setpoint not kept");

    property p_wp;
        @(posedge hclk) disable iff (!hresetn) ce |=> (wp_reg == ($past(af.present) > WP_LEVEL));
    endproperty
    a_wp: assert property (p_wp) else $error("write protect wrong");

    property p_sel_reset;
        @(posedge hclk) disable iff (!hresetn) (ce && !pf.sel_reset_n) |=> !chan_reg;
    endproperty
    a_sel_reset: assert property (p_sel_reset) else $error("selector not reset");

    property p_slot_top;
        @(posedge hclk) disable iff (!hresetn) (ce && af.slot >= SLOT_B0) |=> (addr_reg[1:0] == 2'h0);
    endproperty
    a_slot_top: assert property (p_slot_top) else $error("slot decode wrong");

    property p_fault_pin;
        @(posedge hclk) disable iff (!hresetn) (ce && pf.fan_fail) |=> !fault_n_reg;
    endproperty
    a_fault_pin: assert property (p_fault_pin) else $error("fault pin not low");

    property p_pec_sticky;
        @(posedge hclk) disable iff (!hresetn) (ce && pec_reg && !clrf_w) |=> pec_reg;
    endproperty
    a_pec_sticky: assert property (p_pec_sticky) else $error("comm error lost");

    property p_read_clear;
        @(posedge hclk) disable iff (!hresetn)
            (ce && status_rd && !alarm_evt) |=> (!changed_reg && !restart_reg);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status not cleared by read");

    property p_alert_set;
        @(posedge hclk) disable iff (!hresetn) (ce && alarm_evt) |=> !alert_n_reg;
    endproperty
    a_alert_set: assert property (p_alert_set) else $error("alert not raised");

    property p_restart_bit;
        @(posedge hclk) disable iff (!hresetn) (ce && restart_evt) |=> (restart_reg && out_en_reg);
    endproperty
    a_restart_bit: assert property (p_restart_bit) else $error("restart bit missing");

    property p_capacity;
        @(posedge hclk) disable iff (!hresetn) ce |=> (cap_reg == $past(pf.high_line));
    endproperty
    a_capacity: assert property (p_capacity) else $error("capacity pin wrong");

    property p_pok_warn;
        @(posedge hclk) disable iff (!hresetn) (ce && pf.decay_warn) |=> !pok_reg;
    endproperty
    a_pok_warn: assert property (p_pok_warn) else $error("power warning not low");

endmodule

// File: test/rcs_plant.sv
// rcs_plant: pin, converter and link error side of the rectifier control block
`timescale 1ns/100ps
module rcs_plant (
    input  wire logic               hclk,
    input  wire rcs_pkg::rcs_pins_t pin_cmd,
    input  wire rcs_pkg::rcs_adc_t  adc_cmd,
    input  wire logic [1:0]         err_cmd,
    output rcs_pkg::rcs_pins_t      pins,
    output rcs_pkg::rcs_adc_t       adc,
    output logic                    pec_err_pulse,
    output logic                    data_err_pulse
);
    import rcs_pkg::*;
    logic [1:0] err_q = 2'h0;
    // request and selector reset are held low by the far side as long as commanded
    assign pins = pin_cmd;
    assign adc  = adc_cmd;
    // one pulse per request, no matter how long the bench holds it
    assign pec_err_pulse  = err_cmd[0] & ~err_q[0];
    assign data_err_pulse = err_cmd[1] & ~err_q[1];
    always_ff @(posedge hclk) begin
        err_q <= err_cmd;
    end
endmodule

// File: test/rcs_top_tb.sv
// rcs_top_tb: self-checking bench for the rectifier control block
`timescale 1ns/100ps
module rcs_top_tb;
    import rcs_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        ce = 1'b1;
    logic        hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    rcs_pins_t   pc = PINS_RST;
    rcs_adc_t    ac = 32'h5000C8E6;
    logic [1:0]  err = 2'h0;
    rcs_pins_t   pins;
    rcs_adc_t    adc;
    logic        pec, derr, mo, cap, pw, fn, al, wp, ch, a2, a1, a0, fb, hr;
    logic [7:0]  sp, m, w;
    logic [31:0] ov;
    logic [63:0] q[$];
    logic [63:0] nt;
    logic        rd_ph = 1'b0;
    logic        snp = 1'b0;
    int          num_checks = 0;
    int          miscompares = 0;
    int          i;
    localparam logic [14:0] STEPS [12] = '{{11'h102, 4'hF}, {11'h302, 4'h5}, {11'h102, 4'hF}, {11'h103, 4'hD},
        {11'h100, 4'hB}, {11'h180, 4'hA}, {11'h140, 4'hA}, {11'h108, 4'hA}, {11'h110, 4'h0}, {11'h120, 4'h0},
        {11'h500, 4'h1}, {11'h100, 4'hB}};
    localparam logic [7:0] SC [4] = '{8'hC8, 8'h82, 8'h5A, 8'h1E};
    localparam logic [7:0] SH [8] = '{8'hE6, 8'hBE, 8'hA0, 8'h82, 8'h64, 8'h46, 8'h1E, 8'h0A};
    assign ov = {12'h0, al, a2, a1, a0, mo, cap, pw, fn, wp, ch, fb, hr, sp};

    always #4 hclk = ~hclk;

    rcs_plant i_rcs_plant (.hclk(hclk), .pin_cmd(pc), .adc_cmd(ac), .err_cmd(err), .pins(pins), .adc(adc),
        .pec_err_pulse(pec), .data_err_pulse(derr));

    rcs_top i_rcs_top (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hr), .pins(pins), .adc(adc), .pec_err_pulse(pec), .data_err_pulse(derr),
        .main_out_en(mo), .capacity_hi(cap), .power_ok_warn(pw), .fault_n(fn), .alert_n(al), .eeprom_wp(wp),
        .sel_channel(ch), .bus_addr_bit2(a2), .bus_addr_bit1(a1), .bus_addr_bit0(a0), .setpoint(sp),
        .setpoint_from_bus(fb));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // oldest note belongs to whichever result shows up first
    always @(posedge hclk) begin
        if (rd_ph && hreadyout === 1'b1) begin
            nt = q.pop_front();
            chk(hrdata & nt[63:32], nt[31:0]);
        end else if (snp) begin
            nt = q.pop_front();
            chk(ov & nt[63:32], nt[31:0]);
        end
    end

    task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph  <= ~wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_ph  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
        q.push_back({msk, e});
        xfer(a, 1'b0, 32'h0);
    endtask

    task automatic snap(input logic [31:0] msk, input logic [31:0] e);
        q.push_back({msk, e});
        snp <= 1'b1;
        @(posedge hclk);
        snp <= 1'b0;
        @(posedge hclk);
    endtask

    // pin path latency is fixed: sync, filter, then one output register
    task automatic settle;
        repeat (int'(FILT_CYC) + 8) @(posedge hclk);
    endtask

    task automatic rst;
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    task automatic done(input string s);
        $display("test done: %s", s);
    endtask

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge hclk);
        miscompares++;
        report_and_stop;
    end

    initial begin
        void'($urandom(32'hD28B417A));
        rst;
        snap(32'h89500, 32'h81000);
        rd(REG_CTRL, 32'h7, 32'h0);
        settle;
        for (i = 0; i < 12; i++) begin
            pc <= STEPS[i][14:4];
            settle;
            snap(32'hF000, {16'h0, STEPS[i][3:0], 12'h0});
        end
        done("output enable and status pins");
        m = 8'($urandom_range(200, 1));
        ac.margin <= m;
        settle;
        snap(32'h2FF, {24'h0, m});
        ac.margin <= 8'hE0;
        settle;
        snap(32'h2FF, {24'h0, SETPT_DEFAULT});
        w = 8'($urandom);
        xfer(REG_SETPT, 1'b1, {24'h0, w});
        // setpoint register follows the override one cycle later
        @(posedge hclk);
        snap(32'h2FF, {22'h0, 2'b10, w});
        rd(REG_SETPT, 32'hFF01FF, {8'h0, w, 7'h0, 1'b1, w});
        ac.margin <= m;
        settle;
        snap(32'h2FF, {22'h0, 2'b10, w});
        rst;
        settle;
        snap(32'h2FF, {24'h0, m});
        done("setpoint source");
        for (i = 0; i < 8; i++) begin
            ac <= {m, (i[0] ? 8'h50 : 8'h3C), SC[i % 4], SH[i]};
            settle;
            snap(32'h70800, {13'h0, i[0], i[1:0], 4'h0, i[0], 11'h0});
            rd(REG_ADDR, 32'hFF, {24'h0, 1'b0, 3'(i), i[0], i[0], i[1:0]});
        end
        done("address decode");
        xfer(REG_CTRL, 1'b1, 32'h4);
        snap(32'h400, 32'h400);
        rd(REG_CTRL, 32'h7, 32'h4);
        pc.sel_reset_n <= 1'b0;
        settle;
        pc.sel_reset_n <= 1'b1;
        settle;
        snap(32'h400, 32'h0);
        rd(REG_CTRL, 32'h7, 32'h0);
        done("bus selector");
        rd(REG_STATUS, 32'h37F, 32'h0);
        for (i = 0; i < 2; i++) begin
            err <= 2'(1 << i);
            @(posedge hclk);
            err <= 2'h0;
            rd(REG_STATUS, 32'h2300, 32'h2000 | (32'h100 << i));
            rd(REG_STATUS, 32'h2300, 32'h100 << i);
            xfer(REG_CTRL, 1'b1, 32'h2);
            rd(REG_STATUS, 32'h300, 32'h0);
        end
        pc.fan_fail <= 1'b1;
        settle;
        rd(REG_STATUS, 32'h1, 32'h1);
        snap(32'h80000, 32'h0);
        pc.fan_fail <= 1'b0;
        settle;
        rd(REG_STATUS, 32'h1, 32'h0);
        snap(32'h80000, 32'h80000);
        xfer(REG_CTRL, 1'b1, 32'h1);
        rd(REG_STATUS, 32'h37F, 32'h0);
        pc.ov_shut <= 1'b1;
        settle;
        snap(32'h8000, 32'h0);
        pc.ov_shut <= 1'b0;
        settle;
        snap(32'h88000, 32'h8000);
        rd(REG_STATUS, 32'h1000, 32'h1000);
        rd(REG_STATUS, 32'h1000, 32'h0);
        done("status and restart");
        // a pulse shorter than the filter must not reach the pin
        pc.high_line <= 1'b1;
        repeat (100) @(posedge hclk);
        pc.high_line <= 1'b0;
        settle;
        snap(32'h4000, 32'h0);
        ce <= 1'b0;
        pc.high_line <= 1'b1;
        settle;
        snap(32'h4000, 32'h0);
        ce <= 1'b1;
        settle;
        snap(32'h4000, 32'h4000);
        done("filter and clock enable");
        report_and_stop;
    end
endmodule
